// [hdl/cwf_consts.svh]
// Constants for the CAN wake filter and channel configuration block
`ifndef CWF_CONSTS_SVH
`define CWF_CONSTS_SVH
// Register offsets (word index == byte address / 4)
`define CWF_OFS_CTRL 8'h00
`define CWF_OFS_ID_VAL 8'h04
`define CWF_OFS_ID_MASK 8'h08
`define CWF_OFS_PL_VAL_LO 8'h0C
`define CWF_OFS_PL_VAL_HI 8'h10
`define CWF_OFS_PL_MASK_LO 8'h14
`define CWF_OFS_PL_MASK_HI 8'h18
`define CWF_OFS_TIMEOUT 8'h1C
`define CWF_OFS_NOM_RATE 8'h20
`define CWF_OFS_FAST_RATE 8'h24
`define CWF_OFS_TIMING 8'h28
`define CWF_OFS_STATUS 8'h2C
`define CWF_OFS_ACK 8'h30
// Control field positions
`define CWF_CTRL_MODE_LSB 0
`define CWF_CTRL_NORMAL 2
`define CWF_CTRL_FD_EN 3
`define CWF_CTRL_ID_EXT 4
// Timing field positions
`define CWF_TIM_SP_LSB 0
`define CWF_TIM_SJW_LSB 8
// Status field positions
`define CWF_ST_AWAKE 0
`define CWF_ST_ALERT 1
`define CWF_ST_INACT 2
`define CWF_ST_LOG 3
// Reset values
`define CWF_RST_CTRL 32'h0000_0000
`define CWF_RST_TIMEOUT 32'h0000_03E8
`define CWF_RST_NOM_RATE 32'h0007_A120
`define CWF_RST_FAST_RATE 32'h001E_8480
`define CWF_RST_TIMING 32'h0000_0150
`endif

// [hdl/cwf_pkg.sv]
// Types for the CAN wake filter and channel configuration block
package cwf_pkg;
    typedef enum logic [1:0] {
        CWF_WAKE_OFF,
        CWF_WAKE_ON,
        CWF_WAKE_LOSSLESS,
        CWF_WAKE_KEEP
    } cwf_mode_t;
    typedef enum logic [1:0] {
        CWF_ST_IDLE,
        CWF_ST_RUN,
        CWF_ST_TIMED_OUT
    } cwf_state_t;
endpackage

// [hdl/cwf_wake_channel.sv]
// CAN wake filter, inactivity watch and channel settings for one channel
`timescale 1ns/10ps
`include "cwf_consts.svh"

module cwf_wake_channel #(
    parameter int FD_CAPABLE = 1,
    parameter int TIMEOUT_W = 32
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_bit_tick,
    input wire logic i_rx_done,
    input wire logic i_rx_err,
    input wire logic i_rx_ext,
    input wire logic [28:0] i_rx_id,
    input wire logic [63:0] i_rx_data,
    input wire logic i_ignition,
    input wire logic i_other_wake_sources,
    output logic o_logger_start,
    output logic o_logger_awake,
    output logic o_keep_rx_alive,
    output logic o_tx_allow,
    output logic o_fast_rate_sel,
    output logic [31:0] o_active_rate,
    output logic [7:0] o_sample_point,
    output logic [7:0] o_sjw,
    output logic o_log_entry,
    output logic o_alert
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Counters and the timeout register share this width
    if (TIMEOUT_W < 1 || TIMEOUT_W > 32) begin : g_bad_timeout_w
        $error("TIMEOUT_W must be 1 to 32");
    end
    // The capability flag is a plain yes or no
    if (FD_CAPABLE != 0 && FD_CAPABLE != 1) begin : g_bad_fd_capable
        $error("FD_CAPABLE must be 0 or 1");
    end

    // ****************************************
    // Helper functions
    // ****************************************
    // Shared by the identifier and the payload filter
    function automatic logic mask_match(input logic [63:0] val,
                                        input logic [63:0] cfg,
                                        input logic [63:0] msk);
        mask_match = (((val ^ cfg) & msk) == 64'h0000_0000_0000_0000);
    endfunction

    // Counters stop at the limit so a long silence cannot wrap
    function automatic logic [TIMEOUT_W-1:0] cnt_step(
        input logic [TIMEOUT_W-1:0] cnt,
        input logic tick,
        input logic [TIMEOUT_W-1:0] lim);
        cnt_step = (tick && (cnt < lim)) ? cnt + 1'b1 : cnt;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] ign_sync_reg;
    logic [2:0] oth_sync_reg;
    logic ign_reg;
    logic oth_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ign_sync_reg <= 3'b000;
            oth_sync_reg <= 3'b000;
            ign_reg <= 1'b0;
            oth_reg <= 1'b0;
        end else if (i_ce) begin
            ign_sync_reg <= {ign_sync_reg[1:0], i_ignition};
            oth_sync_reg <= {oth_sync_reg[1:0], i_other_wake_sources};
            // First stage may go metastable; only later stages are read
            // Change counts only once the last two stages agree
            if (ign_sync_reg[2] == ign_sync_reg[1]) begin
                ign_reg <= ign_sync_reg[2];
            end
            if (oth_sync_reg[2] == oth_sync_reg[1]) begin
                oth_reg <= oth_sync_reg[2];
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [31:0] ctrl_reg;
    logic [28:0] id_val_reg;
    logic [28:0] id_mask_reg;
    logic [63:0] pl_val_reg;
    logic [63:0] pl_mask_reg;
    logic [TIMEOUT_W-1:0] timeout_reg;
    logic [31:0] nom_rate_reg;
    logic [31:0] fast_rate_reg;
    logic [15:0] timing_reg;
    logic ack_wr;

    assign ack_wr = i_wr && (i_addr == `CWF_OFS_ACK) && i_wdata[0];

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= `CWF_RST_CTRL;
            id_val_reg <= 29'h0000_0000;
            id_mask_reg <= 29'h0000_0000;
            pl_val_reg <= 64'h0000_0000_0000_0000;
            pl_mask_reg <= 64'h0000_0000_0000_0000;
            timeout_reg <= TIMEOUT_W'(`CWF_RST_TIMEOUT);
            nom_rate_reg <= `CWF_RST_NOM_RATE;
            fast_rate_reg <= `CWF_RST_FAST_RATE;
            timing_reg <= 16'(`CWF_RST_TIMING);
        end else if (i_ce && i_wr) begin
            case (i_addr)
                `CWF_OFS_CTRL: ctrl_reg <= {27'h000_0000, i_wdata[4:0]};
                `CWF_OFS_ID_VAL: id_val_reg <= i_wdata[28:0];
                `CWF_OFS_ID_MASK: id_mask_reg <= i_wdata[28:0];
                `CWF_OFS_PL_VAL_LO: pl_val_reg[31:0] <= i_wdata;
                `CWF_OFS_PL_VAL_HI: pl_val_reg[63:32] <= i_wdata;
                `CWF_OFS_PL_MASK_LO: pl_mask_reg[31:0] <= i_wdata;
                `CWF_OFS_PL_MASK_HI: pl_mask_reg[63:32] <= i_wdata;
                `CWF_OFS_TIMEOUT: timeout_reg <= i_wdata[TIMEOUT_W-1:0];
                // Nominal rate must equal every other node's rate
                `CWF_OFS_NOM_RATE: nom_rate_reg <= i_wdata;
                `CWF_OFS_FAST_RATE: fast_rate_reg <= i_wdata;
                `CWF_OFS_TIMING: timing_reg <= i_wdata[15:0];
                default: ;
            endcase
        end
    end

    cwf_pkg::cwf_mode_t mode;
    logic id_ext;
    logic fd_on;
    assign mode = cwf_pkg::cwf_mode_t'(ctrl_reg[`CWF_CTRL_MODE_LSB +: 2]);
    assign id_ext = ctrl_reg[`CWF_CTRL_ID_EXT];
    assign fd_on = ctrl_reg[`CWF_CTRL_FD_EN] && (FD_CAPABLE != 0);

    // ****************************************
    // Frame filter
    // ****************************************
    logic frame_ok;
    logic [28:0] id_eff_mask;
    logic id_hit;
    logic pl_hit;
    logic match;

    // Errored or partial frames are discarded before any filtering
    assign frame_ok = i_rx_done && !i_rx_err;
    // Standard format compares the low 11 bits only
    assign id_eff_mask = id_ext ? id_mask_reg
                                : {18'h0_0000, id_mask_reg[10:0]};
    // Format must agree; a zero mask then accepts every identifier
    assign id_hit = (i_rx_ext == id_ext)
        && mask_match({35'h0_0000_0000, i_rx_id},
                      {35'h0_0000_0000, id_val_reg},
                      {35'h0_0000_0000, id_eff_mask});
    // Data byte 0 bit 0 of the wire order arrives as bit 0 here
    assign pl_hit = mask_match(i_rx_data, pl_val_reg,
                               pl_mask_reg);
    assign match = frame_ok && id_hit && pl_hit;

    // ****************************************
    // Wake state machine and inactivity timer
    // ****************************************
    cwf_pkg::cwf_state_t state_reg;
    logic [TIMEOUT_W-1:0] idle_cnt_reg;
    logic timeout_hit;

    // Counter saturates at the limit, so the flag holds until traffic or until the state leaves run
    assign timeout_hit = (idle_cnt_reg >= timeout_reg);

    // Counts bit times without valid traffic
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            idle_cnt_reg <= '0;
        end else if (i_ce) begin
            if (frame_ok || state_reg != cwf_pkg::CWF_ST_RUN) begin
                idle_cnt_reg <= '0;
            end else begin
                idle_cnt_reg <= cnt_step(idle_cnt_reg, i_bit_tick,
                                         timeout_reg);
            end
        end
    end

    // Outside keep mode sustain only on matching frames, so track match age separately
    logic [TIMEOUT_W-1:0] nomatch_cnt_reg;
    logic nomatch_hit;
    assign nomatch_hit = (nomatch_cnt_reg >= timeout_reg);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            nomatch_cnt_reg <= '0;
        end else if (i_ce) begin
            if (match || state_reg != cwf_pkg::CWF_ST_RUN) begin
                nomatch_cnt_reg <= '0;
            end else begin
                nomatch_cnt_reg <= cnt_step(nomatch_cnt_reg, i_bit_tick,
                                            timeout_reg);
            end
        end
    end

    // Keep mode starts on ignition alone; release also needs the other sources low and no CAN traffic for the timeout
    logic start_ev;
    always_comb begin
        case (mode)
            cwf_pkg::CWF_WAKE_OFF: start_ev = 1'b0;
            cwf_pkg::CWF_WAKE_ON: start_ev = match;
            cwf_pkg::CWF_WAKE_LOSSLESS: start_ev = match;
            cwf_pkg::CWF_WAKE_KEEP: start_ev = ign_reg;
            default: start_ev = 1'b0;
        endcase
    end

    logic keep_mode;
    logic release_ev;
    assign keep_mode = (mode == cwf_pkg::CWF_WAKE_KEEP);
    assign release_ev = keep_mode
        ? (!ign_reg && !oth_reg && timeout_hit)
        : (timeout_hit || nomatch_hit);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= cwf_pkg::CWF_ST_IDLE;
        end else if (i_ce) begin
            case (state_reg)
                cwf_pkg::CWF_ST_IDLE: begin
                    if (start_ev) begin
                        state_reg <= cwf_pkg::CWF_ST_RUN;
                    end
                end
                cwf_pkg::CWF_ST_RUN: begin
                    if (release_ev) begin
                        state_reg <= cwf_pkg::CWF_ST_TIMED_OUT;
                    end
                end
                cwf_pkg::CWF_ST_TIMED_OUT: begin
                    // One cycle out of run so a restart is a fresh pulse
                    state_reg <= cwf_pkg::CWF_ST_IDLE;
                end
                default: state_reg <= cwf_pkg::CWF_ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Outputs and alert
    // ****************************************
    logic to_ev;
    assign to_ev = (state_reg == cwf_pkg::CWF_ST_RUN) && release_ev;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_logger_start <= 1'b0;
            o_logger_awake <= 1'b0;
            o_keep_rx_alive <= 1'b0;
        end else if (i_ce) begin
            o_logger_start <= (state_reg == cwf_pkg::CWF_ST_IDLE)
                && start_ev;
            // Awake drops on the same edge that reports the timeout
            o_logger_awake <= ((state_reg == cwf_pkg::CWF_ST_RUN)
                && !release_ev)
                || ((state_reg == cwf_pkg::CWF_ST_IDLE) && start_ev);
            // Receiver stays powered in idle; costs idle current
            o_keep_rx_alive <= (mode == cwf_pkg::CWF_WAKE_LOSSLESS);
        end
    end

    // New timeout wins over a same-cycle acknowledge
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_log_entry <= 1'b0;
            o_alert <= 1'b0;
        end else if (i_ce) begin
            o_log_entry <= to_ev;
            if (to_ev) begin
                o_alert <= 1'b1;
            end else if (ack_wr) begin
                o_alert <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tx_allow <= 1'b0;
            o_fast_rate_sel <= 1'b0;
            o_active_rate <= `CWF_RST_NOM_RATE;
            o_sample_point <= 8'h00;
            o_sjw <= 8'h00;
        end else if (i_ce) begin
            o_tx_allow <= ctrl_reg[`CWF_CTRL_NORMAL];
            o_fast_rate_sel <= fd_on;
            o_active_rate <= fd_on ? fast_rate_reg : nom_rate_reg;
            // One sample point and SJW serve both bit rates
            o_sample_point <= timing_reg[`CWF_TIM_SP_LSB +: 8];
            o_sjw <= timing_reg[`CWF_TIM_SJW_LSB +: 8];
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Status is live; the log bit is only a one-cycle pulse
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_addr)
            `CWF_OFS_CTRL: rd_mux = ctrl_reg;
            `CWF_OFS_ID_VAL: rd_mux = {3'b000, id_val_reg};
            `CWF_OFS_ID_MASK: rd_mux = {3'b000, id_mask_reg};
            `CWF_OFS_PL_VAL_LO: rd_mux = pl_val_reg[31:0];
            `CWF_OFS_PL_VAL_HI: rd_mux = pl_val_reg[63:32];
            `CWF_OFS_PL_MASK_LO: rd_mux = pl_mask_reg[31:0];
            `CWF_OFS_PL_MASK_HI: rd_mux = pl_mask_reg[63:32];
            `CWF_OFS_TIMEOUT: rd_mux = 32'(timeout_reg);
            `CWF_OFS_NOM_RATE: rd_mux = nom_rate_reg;
            `CWF_OFS_FAST_RATE: rd_mux = fast_rate_reg;
            `CWF_OFS_TIMING: rd_mux = {16'h0000, timing_reg};
            `CWF_OFS_STATUS: begin
                rd_mux[`CWF_ST_AWAKE] = (state_reg == cwf_pkg::CWF_ST_RUN);
                rd_mux[`CWF_ST_ALERT] = o_alert;
                rd_mux[`CWF_ST_INACT] = timeout_hit;
                rd_mux[`CWF_ST_LOG] = o_log_entry;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero outside the answer cycle, so old data never lingers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_ce) begin
            o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

// [tb/cwf_wake_channel_monitor.sv]
// Port checker for the CAN wake channel
`timescale 1ns/10ps
module cwf_wake_channel_monitor (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic o_logger_start,
    input wire logic o_logger_awake,
    input wire logic o_log_entry,
    input wire logic o_alert
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    logic ack_w;
    assign ack_w = i_ce && i_wr && i_addr == 8'h30 && i_wdata[0];
    a_start_one_cycle:
    assert property (o_logger_start |=> !o_logger_start)
        else $error("start pulse too long");
    a_start_with_awake:
    assert property (o_logger_start |-> o_logger_awake)
        else $error("start without awake");
    a_awake_from_start:
    assert property ($rose(o_logger_awake) |-> o_logger_start)
        else $error("awake rose without start");
    a_log_one_cycle:
    assert property (o_log_entry |=> !o_log_entry)
        else $error("log pulse too long");
    a_log_with_alert:
    assert property (o_log_entry |-> o_alert)
        else $error("log entry without alert");
    a_log_releases:
    assert property (o_log_entry |-> !o_logger_awake)
        else $error("still awake after timeout");
    a_alert_sticky:
    assert property (o_alert && !ack_w |=> o_alert)
        else $error("alert dropped without ack");
    a_ack_clears:
    assert property (ack_w |=> !o_alert || o_log_entry)
        else $error("ack did not clear alert");
    c_start: cover property (o_logger_start);
    c_timeout: cover property (o_log_entry);
    c_ack: cover property (o_alert && ack_w);
endmodule

bind cwf_wake_channel cwf_wake_channel_monitor cwf_wake_channel_monitor_inst (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .o_logger_start(o_logger_start), .o_logger_awake(o_logger_awake),
    .o_log_entry(o_log_entry), .o_alert(o_alert)
);

// [tb/cwf_bus_node.sv]
// Model of another bus node handing received frames to the channel
`timescale 1ns/10ps
module cwf_bus_node #(
    parameter int TICK_DIV = 4
) (
    input wire logic i_core_clk,
    output logic o_bit_tick,
    output logic o_rx_done,
    output logic o_rx_err,
    output logic o_rx_ext,
    output logic [28:0] o_rx_id,
    output logic [63:0] o_rx_data
);
    // ****************************************
    // Bit time and frames
    // ****************************************
    int tick_cnt = 0;
    initial begin
        o_bit_tick = 1'b0;
        o_rx_done = 1'b0;
        o_rx_err = 1'b0;
        o_rx_ext = 1'b0;
        o_rx_id = 29'h0;
        o_rx_data = 64'h0;
    end
    // Same bit time as the channel, else no traffic at all
    always @(posedge i_core_clk) begin
        tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
        o_bit_tick <= (tick_cnt == TICK_DIV - 1);
    end
    task send(input logic ext, input logic [28:0] id, input logic [63:0] d,
              input logic err);
        @(posedge i_core_clk);
        o_rx_done <= 1'b1;
        o_rx_err <= err;
        o_rx_ext <= ext;
        o_rx_id <= id;
        o_rx_data <= d;
        @(posedge i_core_clk);
        o_rx_done <= 1'b0;
        o_rx_err <= 1'b0;
        o_rx_ext <= ~ext;
        // Released lines inverted so stale copies never match
        o_rx_id <= ~id;
        o_rx_data <= ~d;
    endtask
endmodule

// [tb/cwf_wake_channel_test.sv]
// Self-checking bench for the CAN wake channel
`timescale 1ns/10ps
module cwf_wake_channel_test;
    // ****************************************
    // Signals and cases
    // ****************************************
    typedef struct packed {
        logic [3:0] md;
        logic [15:0] iv, im, pv, pm, id, dt;
        logic ex;
    } cwf_row_t;
    cwf_row_t rows [8] = '{
        '{4'h1,16'h0,16'h0,16'h0,16'h0,16'h07FF,16'hFFFF,1'b1},
        '{4'h1,16'h0016,16'h001C,16'h0,16'h0,16'h0115,16'h0,1'b1},
        '{4'h1,16'h0016,16'h001C,16'h0,16'h0,16'h0119,16'h0,1'b0},
        '{4'h1,16'h0,16'h0,16'h0010,16'h0014,16'h0,16'h0011,1'b1},
        '{4'h1,16'h0,16'h0,16'h0010,16'h0014,16'h0,16'h001C,1'b0},
        '{4'h1,16'h0016,16'h001C,16'h0010,16'h0014,16'h0115,16'h001C,1'b0},
        '{4'h0,16'h0,16'h0,16'h0,16'h0,16'h0005,16'h0,1'b0},
        '{4'h2,16'h0,16'h0,16'h0,16'h0,16'h0005,16'h0,1'b1}};
    logic clk = 0, rst_b = 0, wr_s = 0, rd_s = 0, ign = 0, oth = 0, ce = 1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdv, rdata, rate;
    logic start, awake, alive, txa, fsel, logent, alert;
    logic tick, done, err, ext;
    logic [7:0] sp, sjw;
    logic [28:0] rid;
    logic [63:0] rdat;
    int err_count = 0, n_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    cwf_bus_node cwf_bus_node_inst (.i_core_clk(clk), .o_bit_tick(tick),
        .o_rx_done(done), .o_rx_err(err), .o_rx_ext(ext), .o_rx_id(rid),
        .o_rx_data(rdat));
    cwf_wake_channel #(.FD_CAPABLE(1), .TIMEOUT_W(32)) cwf_wake_channel_inst (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
        .i_bit_tick(tick), .i_rx_done(done), .i_rx_err(err), .i_rx_ext(ext),
        .i_rx_id(rid), .i_rx_data(rdat), .i_ignition(ign),
        .i_other_wake_sources(oth), .o_logger_start(start),
        .o_logger_awake(awake), .o_keep_rx_alive(alive), .o_tx_allow(txa),
        .o_fast_rate_sel(fsel), .o_active_rate(rate), .o_sample_point(sp),
        .o_sjw(sjw), .o_log_entry(logent), .o_alert(alert));
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        rdv = rdata;
    endtask
    task do_rst;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    task wait_hi(input logic lg);
        int k;
        k = 0;
        #1;
        while (k < 300 && (lg ? logent : start) !== 1'b1) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(32'(k < 300), 32'h1);
    endtask
    task tally_and_finish;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard, run needs well under 3000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            do_rst();
            wr(8'h00, {28'h0, rows[i].md});
            wr(8'h04, {16'h0, rows[i].iv});
            wr(8'h08, {16'h0, rows[i].im});
            wr(8'h0C, {16'h0, rows[i].pv});
            wr(8'h14, {16'h0, rows[i].pm});
            cwf_bus_node_inst.send(1'b0, {13'h0, rows[i].id},
                                   {48'h0, rows[i].dt}, 1'b0);
            #1;
            chk(start, rows[i].ex);
        end
        chk(alive, 1'b1);
        do_rst();
        #1;
        chk(rate, 32'h0007_A120);
        chk(fsel, 1'b0);
        chk(alive, 1'b0);
        chk(txa, 1'b0);
        rd(8'h1C);
        chk(rdv, 32'h0000_03E8);
        rd(8'h28);
        chk(rdv, 32'h0000_0150);
        rd(8'h40);
        chk(rdv, 32'h0);
        // Low clock enable must swallow a write
        @(posedge clk);
        ce <= 1'b0;
        wr(8'h28, 32'h0000_0777);
        ce <= 1'b1;
        rd(8'h28);
        chk(rdv, 32'h0000_0150);
        @(posedge clk);
        #1;
        chk(rdata, 32'h0);
        wr(8'h00, 32'h0000_000C);
        wr(8'h28, 32'h0000_0322);
        repeat (2) @(posedge clk);
        #1;
        chk(txa, 1'b1);
        chk(fsel, 1'b1);
        chk(rate, 32'h001E_8480);
        chk(sp, 8'h22);
        chk(sjw, 8'h03);
        // Extended id, top payload bit only
        wr(8'h00, 32'h0000_0011);
        wr(8'h04, 32'h1000_0000);
        wr(8'h08, 32'h1000_0000);
        wr(8'h10, 32'h8000_0000);
        wr(8'h18, 32'h8000_0000);
        cwf_bus_node_inst.send(1'b1, 29'h1000_0000, 64'h8000_0000_0000_0000,
                               1'b1);
        #1;
        chk(start, 1'b0);
        cwf_bus_node_inst.send(1'b0, 29'h1000_0000, 64'h8000_0000_0000_0000,
                               1'b0);
        #1;
        chk(start, 1'b0);
        cwf_bus_node_inst.send(1'b1, 29'h1000_0000, 64'h7FFF_FFFF_FFFF_FFFF,
                               1'b0);
        #1;
        chk(start, 1'b0);
        cwf_bus_node_inst.send(1'b1, 29'h1000_0000, 64'h8000_0000_0000_0000,
                               1'b0);
        #1;
        chk(start, 1'b1);
        wr(8'h1C, 32'h0000_0005);
        wait_hi(1'b1);
        chk(awake, 1'b0);
        chk(alert, 1'b1);
        rd(8'h2C);
        chk(rdv[1], 1'b1);
        wr(8'h30, 32'h0000_0001);
        #1;
        chk(alert, 1'b0);
        // Keep-awake: ignition starts, every source must drop
        do_rst();
        wr(8'h1C, 32'h0000_0005);
        wr(8'h00, 32'h0000_0003);
        ign <= 1'b1;
        oth <= 1'b1;
        wait_hi(1'b0);
        repeat (60) @(posedge clk);
        ign <= 1'b0;
        repeat (60) @(posedge clk);
        oth <= 1'b0;
        #1;
        chk(awake, 1'b1);
        wait_hi(1'b1);
        tally_and_finish();
    end
endmodule
